// >>> core/timer_input_capture.sv
// module: 16-bit up-counter with four input capture channels
`timescale 1ns/10ps
module timer_input_capture (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // avalon-mm slave
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // channel pins a..d, bit 0 is chan_a_pin
    input  wire logic [3:0]  chan_pin_in,
    output logic      [3:0]  chan_pin_out,
    output logic      [3:0]  chan_pin_oe,
    // count sources and oscillator trigger
    input  wire logic        ext_count_clock_pin,
    input  wire logic        fast_osc_clock,
    input  wire logic        fast_osc_divided_clock,
    input  wire logic        low_speed_osc_trigger,
    // request pulses
    output logic      [3:0]  capture_req,
    output logic             overflow_req
);
    timer_capture_pkg::bus_e  bus_state;
    timer_capture_pkg::ctrl_s ctrl;
    logic [2:0]  timer_mode_reg;
    logic [6:0]  capture_ab_io_control;
    logic [7:0]  capture_cd_io_control;
    logic [4:0]  status;
    logic [15:0] up_counter;
    logic [15:0] general_reg [4];
    logic [3:0]  port_out;
    logic [3:0]  port_oe;
    logic [3:0]  pin_level;
    logic [3:0]  pin_hit;
    logic [3:0]  cap_ev;
    logic [3:0]  mode_sel;
    logic [1:0]  edge_sel [4];
    logic [31:0] next_readdata;
    logic        tick;
    logic        osc_hit;
    logic        wr_go;
    logic        running;
    logic        buffer_c_enable;
    logic        buffer_d_enable;
    logic        match_clear;
    logic        cap_clear;
    logic        ovf_ev;
    logic        counter_write;
    timer_capture_pkg::edge_s osc_edge;

    // merge written bytes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    assign running = timer_mode_reg[timer_capture_pkg::MODE_START_BIT];
    assign buffer_c_enable = timer_mode_reg[timer_capture_pkg::MODE_BUFC_BIT];
    assign buffer_d_enable = timer_mode_reg[timer_capture_pkg::MODE_BUFD_BIT];
    assign wr_go = write && bus_state == timer_capture_pkg::BUS_ACK;

    // per-channel field split; mode select 1 means capture, 0 port
    assign mode_sel = {capture_cd_io_control[6], capture_cd_io_control[2],
                       capture_ab_io_control[6], capture_ab_io_control[2]};
    assign edge_sel[0] = capture_ab_io_control[1:0];
    assign edge_sel[1] = capture_ab_io_control[5:4];
    assign edge_sel[2] = capture_cd_io_control[1:0];
    assign edge_sel[3] = capture_cd_io_control[5:4];

    // count source
    count_source u_src (
        .clock                  (clock),
        .resetn                 (resetn),
        .count_src              (ctrl.count_src),
        .ext_count_clock_pin    (ext_count_clock_pin),
        .fast_osc_clock         (fast_osc_clock),
        .fast_osc_divided_clock (fast_osc_divided_clock),
        .tick                   (tick)
    );

    // pin conditioning and edge selection, one per channel
    for (genvar i = 0; i < 4; i++) begin : g_chan
        timer_capture_pkg::edge_s e;
        input_conditioner u_cond (
            .clock     (clock),
            .resetn    (resetn),
            .raw       (chan_pin_in[i]),
            .filter_en (ctrl.filter_en),
            .level     (pin_level[i]),
            .edges     (e)
        );
        always_comb begin
            case (edge_sel[i])
                timer_capture_pkg::EDGE_RISE: pin_hit[i] = e.rise;
                timer_capture_pkg::EDGE_FALL: pin_hit[i] = e.fall;
                timer_capture_pkg::EDGE_BOTH: pin_hit[i] = e.rise | e.fall;
                default:                      pin_hit[i] = 1'b0;
            endcase
        end
    end

    // low-speed oscillator trigger, same edge choice as channel A
    input_conditioner u_osc (
        .clock     (clock),
        .resetn    (resetn),
        .raw       (low_speed_osc_trigger),
        .filter_en (ctrl.filter_en),
        .level     (),
        .edges     (osc_edge)
    );

    // oscillator edge under channel A's edge field
    always_comb begin
        case (edge_sel[0])
            timer_capture_pkg::EDGE_RISE: osc_hit = osc_edge.rise;
            timer_capture_pkg::EDGE_FALL: osc_hit = osc_edge.fall;
            timer_capture_pkg::EDGE_BOTH: osc_hit = osc_edge.rise
                                                  | osc_edge.fall;
            default:                      osc_hit = 1'b0;
        endcase
    end

    // capture events; channels act independently and together
    // a buffering channel's own pin no longer captures
    assign cap_ev[0] = mode_sel[0] && (capture_ab_io_control[3]
                       ? pin_hit[0] : osc_hit);
    assign cap_ev[1] = mode_sel[1] && pin_hit[1];
    assign cap_ev[2] = mode_sel[2] && pin_hit[2] && !buffer_c_enable;
    assign cap_ev[3] = mode_sel[3] && pin_hit[3] && !buffer_d_enable;

    // counter clear and overflow conditions
    assign counter_write = wr_go && address == timer_capture_pkg::COUNTER_OFS;
    assign match_clear = ctrl.counter_clear_select
                         && up_counter == general_reg[0];
    assign cap_clear = ctrl.clear_on_capture && cap_ev[0];
    assign ovf_ev = running && tick && !counter_write && !cap_clear
                    && !match_clear
                    && up_counter == timer_capture_pkg::COUNTER_MAX;

    // up-counter: software load, capture clear, match clear, count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            up_counter <= timer_capture_pkg::COUNTER_RESET;
        end else if (counter_write) begin
            up_counter <= merge16(up_counter, writedata, byteenable);
        end else if (cap_clear) begin
            up_counter <= timer_capture_pkg::COUNTER_RESET;
        end else if (running && tick) begin
            if (match_clear) begin
                up_counter <= timer_capture_pkg::COUNTER_RESET;
            end else begin
                up_counter <= up_counter + 16'h0001;
            end
        end
    end

    // general registers: capture, buffer transfer, software write
    for (genvar i = 0; i < 4; i++) begin : g_gr
        logic buf_load;
        assign buf_load = (i == 2) ? cap_ev[0] && buffer_c_enable
                        : (i == 3) ? cap_ev[1] && buffer_d_enable
                        : 1'b0;
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                general_reg[i] <= timer_capture_pkg::COUNTER_RESET;
            end else if (cap_ev[i]) begin
                general_reg[i] <= up_counter;
            end else if (buf_load) begin
                general_reg[i] <= general_reg[i ^ 2];
            end else if (wr_go && address == timer_capture_pkg::GR_BASE_OFS
                         + 12'(4 * i)) begin
                general_reg[i] <= merge16(general_reg[i], writedata,
                                          byteenable);
            end
        end
    end
    // control registers written by software
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_mode_reg        <= 3'h0;
            ctrl                  <= '0;
            port_out              <= 4'h0;
            port_oe               <= 4'h0;
            capture_ab_io_control <= timer_capture_pkg::IO_AB_RESET[6:0];
            capture_cd_io_control <= timer_capture_pkg::IO_CD_RESET;
        end else if (wr_go && byteenable[0]) begin
            case (address)
                timer_capture_pkg::MODE_OFS:
                    timer_mode_reg <= writedata[2:0];
                timer_capture_pkg::CTRL_OFS:
                    ctrl <= writedata[5:0];
                timer_capture_pkg::PORT_OFS: begin
                    port_out <= writedata[3:0];
                    port_oe  <= writedata[7:4];
                end
                timer_capture_pkg::IO_AB_OFS:
                    capture_ab_io_control <= writedata[6:0];
                timer_capture_pkg::IO_CD_OFS:
                    capture_cd_io_control <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // sticky status: hardware set wins over write-one-to-clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status <= 5'h00;
        end else begin
            status <= (status & ~((wr_go && byteenable[0]
                        && address == timer_capture_pkg::STATUS_OFS)
                        ? writedata[4:0] : 5'h00))
                      | {ovf_ev, cap_ev};
        end
    end

    // request pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            capture_req  <= 4'h0;
            overflow_req <= 1'b0;
        end else begin
            capture_req  <= cap_ev;
            overflow_req <= ovf_ev;
        end
    end

    // pins in port mode with port_oe set drive the port latch
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chan_pin_out <= 4'h0;
            chan_pin_oe  <= 4'h0;
        end else begin
            chan_pin_out <= port_out;
            chan_pin_oe  <= port_oe & ~mode_sel;
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            timer_capture_pkg::MODE_OFS:
                next_readdata[2:0] = timer_mode_reg;
            timer_capture_pkg::CTRL_OFS:
                next_readdata[5:0] = ctrl;
            timer_capture_pkg::STATUS_OFS:
                next_readdata[4:0] = status;
            timer_capture_pkg::COUNTER_OFS:
                next_readdata[15:0] = up_counter;
            12'h110: next_readdata[15:0] = general_reg[0];
            12'h114: next_readdata[15:0] = general_reg[1];
            12'h118: next_readdata[15:0] = general_reg[2];
            12'h11C: next_readdata[15:0] = general_reg[3];
            timer_capture_pkg::PORT_OFS:
                next_readdata[11:0] = {pin_level, port_oe, port_out};
            timer_capture_pkg::IO_AB_OFS:
                next_readdata[7:0] = {1'b1, capture_ab_io_control};
            timer_capture_pkg::IO_CD_OFS:
                next_readdata[7:0] = capture_cd_io_control;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // bus handshake: one wait cycle, then a single acknowledge cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_state   <= timer_capture_pkg::BUS_IDLE;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            case (bus_state)
                timer_capture_pkg::BUS_IDLE: begin
                    if (read || write) begin
                        bus_state   <= timer_capture_pkg::BUS_ACK;
                        waitrequest <= 1'b0;
                        // read data holds until the next read
                        if (read) begin
                            readdata <= next_readdata;
                        end
                    end
                end
                timer_capture_pkg::BUS_ACK: begin
                    bus_state   <= timer_capture_pkg::BUS_IDLE;
                    waitrequest <= 1'b1;
                end
                default: begin
                    bus_state   <= timer_capture_pkg::BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end
endmodule

// >>> core/timer_capture_pkg.sv
// package: register map, field codes and shared types of the capture timer
package timer_capture_pkg;

    // register byte offsets on the bus
    localparam logic [11:0] MODE_OFS    = 12'h100;
    localparam logic [11:0] CTRL_OFS    = 12'h104;
    localparam logic [11:0] STATUS_OFS  = 12'h108;
    localparam logic [11:0] COUNTER_OFS = 12'h10C;
    localparam logic [11:0] GR_BASE_OFS = 12'h110;
    localparam logic [11:0] PORT_OFS    = 12'h120;
    localparam logic [11:0] IO_AB_OFS   = 12'h124;
    localparam logic [11:0] IO_CD_OFS   = 12'h128;

    // values after reset, and the counter maximum
    localparam logic [7:0]  IO_AB_RESET   = 8'h88;
    localparam logic [7:0]  IO_CD_RESET   = 8'h88;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COUNTER_MAX   = 16'hFFFF;

    // field positions
    localparam int MODE_START_BIT = 0;
    localparam int MODE_BUFC_BIT  = 1;
    localparam int MODE_BUFD_BIT  = 2;
    localparam int STATUS_OVF_BIT = 4;
    localparam int PORT_LEVEL_LSB = 8;

    // count source codes
    localparam logic [2:0] SRC_F1       = 3'h0;
    localparam logic [2:0] SRC_F2       = 3'h1;
    localparam logic [2:0] SRC_F4       = 3'h2;
    localparam logic [2:0] SRC_F8       = 3'h3;
    localparam logic [2:0] SRC_F32      = 3'h4;
    localparam logic [2:0] SRC_EXT      = 3'h5;
    localparam logic [2:0] SRC_FAST     = 3'h6;
    localparam logic [2:0] SRC_FAST_DIV = 3'h7;

    // capture edge codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // counter control register layout, bit 5 down to bit 0
    typedef struct packed {
        logic       filter_en;
        logic       clear_on_capture;
        logic       counter_clear_select;
        logic [2:0] count_src;
    } ctrl_s;

    // conditioned input edges
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_e;

endpackage

// >>> core/input_conditioner.sv
// module: four-flop synchroniser, optional filter and edge detector
`timescale 1ns/10ps
module input_conditioner (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     resetn,
    // raw asynchronous input and filter switch
    input  wire logic                     raw,
    input  wire logic                     filter_en,
    // accepted level and its edges
    output logic                          level,
    output timer_capture_pkg::edge_s      edges
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic sync4;
    logic agree;

    // synchroniser chain; sync1 feeds sync2 only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            sync4 <= 1'b0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            sync4 <= sync3;
        end
    end

    // filter wants three matching samples, else two
    assign agree = filter_en ? (sync2 == sync3 && sync3 == sync4)
                             : (sync2 == sync3);

    // accept the level and flag one-cycle edges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level <= 1'b0;
            edges <= '0;
        end else begin
            edges.rise <= agree && sync3 && !level;
            edges.fall <= agree && !sync3 && level;
            if (agree) begin
                level <= sync3;
            end
        end
    end
endmodule

// >>> core/count_source.sv
// module: count source selection, gives one tick per counted event
`timescale 1ns/10ps
module count_source (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // source select
    input  wire logic [2:0] count_src,
    // external and oscillator clocks, sampled as plain inputs
    input  wire logic       ext_count_clock_pin,
    input  wire logic       fast_osc_clock,
    input  wire logic       fast_osc_divided_clock,
    // one-cycle count pulse
    output logic            tick
);
    logic [4:0] prescale;
    logic [2:0] raw_in;
    logic [2:0] rise_in;
    logic       next_tick;

    assign raw_in = {fast_osc_divided_clock, fast_osc_clock,
                     ext_count_clock_pin};

    // rising edges of the outside sources; sources near the system
    // clock rate are undersampled, a known limit of this block
    for (genvar k = 0; k < 3; k++) begin : g_src
        timer_capture_pkg::edge_s e;
        input_conditioner u_cond (
            .clock     (clock),
            .resetn    (resetn),
            .raw       (raw_in[k]),
            .filter_en (1'b0),
            .level     (),
            .edges     (e)
        );
        assign rise_in[k] = e.rise;
    end

    // free-running divider for the divided system clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prescale <= 5'h00;
        end else begin
            prescale <= prescale + 5'h01;
        end
    end

    // pick the source
    always_comb begin
        case (count_src)
            timer_capture_pkg::SRC_F1:       next_tick = 1'b1;
            timer_capture_pkg::SRC_F2:       next_tick = prescale[0];
            timer_capture_pkg::SRC_F4:       next_tick = &prescale[1:0];
            timer_capture_pkg::SRC_F8:       next_tick = &prescale[2:0];
            timer_capture_pkg::SRC_F32:      next_tick = &prescale;
            timer_capture_pkg::SRC_EXT:      next_tick = rise_in[0];
            timer_capture_pkg::SRC_FAST:     next_tick = rise_in[1];
            default:                         next_tick = rise_in[2];
        endcase
    end

    // registered tick
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick <= 1'b0;
        end else begin
            tick <= next_tick;
        end
    end
endmodule

// >>> test/timer_capture_properties.sv
// checker: bus handshake, request pulses and port timing of the timer
`timescale 1ns/10ps
module timer_capture_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // bus handshake
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // pins and requests
    input wire logic [3:0]  chan_pin_in,
    input wire logic [3:0]  chan_pin_oe,
    input wire logic [3:0]  capture_req,
    input wire logic        overflow_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // bus answers each taken request one cycle later, for one cycle
    a_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("acknowledge longer than one cycle");
    a_no_spurious: assert property (
        !read && !write |=> waitrequest)
        else $error("acknowledge without request");
    a_rdata_hold: assert property (
        !(read && waitrequest) |=> $stable(readdata))
        else $error("read data changed without a read");
    // port enables move only on an acknowledged write
    a_oe_by_write: assert property (
        $changed(chan_pin_oe) |-> $past(write && !waitrequest, 2))
        else $error("pin enable changed without a write");
    // requests are single pulses
    a_ovf_pulse: assert property (
        overflow_req |=> !overflow_req [*8])
        else $error("overflow request not a single pulse");
    a_req_single: assert property (
        (capture_req & $past(capture_req)) == 4'h0)
        else $error("capture request longer than one cycle");
    // a capture on b follows a pin change at the synchroniser delay
    a_capb_cause: assert property (
        capture_req[1] |->
        $past(chan_pin_in[1], 4) != $past(chan_pin_in[1], 9))
        else $error("capture on b without pin edge");
    c_capture_b: cover property (capture_req[1]);
    c_overflow: cover property (overflow_req);
    c_read_ack: cover property (read && !waitrequest);
endmodule

// >>> test/pin_source.sv
// partner: external signal source on the capture pins
`timescale 1ns/10ps
module pin_source (
    // clock
    input  wire logic       clock,
    // wanted levels and the timer's own drive
    input  wire logic [3:0] want,
    input  wire logic [3:0] dut_oe,
    input  wire logic [3:0] dut_out,
    // resolved pin levels
    output logic      [3:0] pin
);
    logic [3:0] drv;
    // source changes its levels just after a clock edge
    always_ff @(posedge clock) drv <= want;
    // timer drive wins where its port enable is set
    assign pin = (dut_oe & dut_out) | (~dut_oe & drv);
endmodule

// >>> test/testbench.sv
// testbench: register-level tests of the capture timer
`timescale 1ns/10ps
module testbench;
    logic        clock, resetn, read, write, osc, waitrequest, overflow_req;
    logic        ext;
    logic [11:0] address;
    logic [31:0] writedata, readdata, rdat;
    logic [3:0]  pin_in, pin_out, pin_oe, capture_req, want;
    logic [7:0]  ab;
    int          mismatches, cmp_count, n, c0;
    int          caps[4];
    // far side of the capture pins
    pin_source src (.clock(clock), .want(want), .dut_oe(pin_oe),
                    .dut_out(pin_out), .pin(pin_in));
    timer_input_capture dut (
        .clock(clock), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
        .ext_count_clock_pin(ext), .fast_osc_clock(1'b0),
        .fast_osc_divided_clock(1'b0), .low_speed_osc_trigger(osc),
        .capture_req(capture_req), .overflow_req(overflow_req));
    always #12.5 clock = ~clock;
    // count capture pulses per channel
    always @(negedge clock)
        for (int k = 0; k < 4; k++) caps[k] += capture_req[k];
    task end_of_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rdat = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            mismatches++;
            end_of_test;
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask
    // raise pins and trigger, then drop them, leaving sync time
    task pulse(input logic [3:0] p, input logic o);
        @(posedge clock);
        want <= p;
        osc <= o;
        repeat (12) @(posedge clock);
        want <= 4'h0;
        osc <= 1'b0;
        repeat (12) @(posedge clock);
    endtask
    initial begin
        clock = 0; resetn = 0; read = 0; write = 0; address = 0; ext = 0;
        writedata = 0; osc = 0; want = 0; mismatches = 0; cmp_count = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        rdchk(timer_capture_pkg::IO_AB_OFS, 32'h88);
        rdchk(12'h000, 32'h0);
        bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'h1234);
        rdchk(timer_capture_pkg::COUNTER_OFS, 32'h1234);
        // run, stop, and hold the count
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h1);
        repeat (20) @(posedge clock);
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h0);
        bus(1'b0, timer_capture_pkg::COUNTER_OFS, 32'h0);
        check(rdat > 32'h1234, 32'h1);
        repeat (10) @(posedge clock);
        rdchk(timer_capture_pkg::COUNTER_OFS, rdat);
        // every edge code on b, a rising alongside, counter held
        for (int code = 0; code < 3; code++) begin
            ab = {2'b01, code[1:0], 4'hC};
            bus(1'b1, timer_capture_pkg::IO_AB_OFS, {24'h0, ab});
            rdchk(timer_capture_pkg::IO_AB_OFS, {24'h0, ab | 8'h80});
            bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'h0100 + code);
            c0 = caps[1];
            pulse(4'h3, 1'b0);
            check(caps[1] - c0, (code == 2) ? 2 : 1);
            rdchk(timer_capture_pkg::GR_BASE_OFS + 12'h004,
                  32'h0100 + code);
        end
        rdchk(timer_capture_pkg::GR_BASE_OFS, 32'h0102);
        // oscillator trigger: selected, pin selected, capture off
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, timer_capture_pkg::IO_AB_OFS, (k == 0) ? 32'h04 :
                (k == 1) ? 32'h0C : 32'h00);
            c0 = caps[0];
            pulse(4'h0, 1'b1);
            check(caps[0] - c0, (k == 0) ? 1 : 0);
        end
        // channel a as plain port driving high
        bus(1'b1, timer_capture_pkg::PORT_OFS, 32'h11);
        repeat (8) @(posedge clock);
        check({pin_oe, pin_out}, 32'h11);
        rdchk(timer_capture_pkg::PORT_OFS, 32'h111);
        bus(1'b1, timer_capture_pkg::PORT_OFS, 32'h0);
        // clear on match with register a
        bus(1'b1, timer_capture_pkg::GR_BASE_OFS, 32'h5);
        bus(1'b1, timer_capture_pkg::CTRL_OFS, 32'h08);
        bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'h0);
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h1);
        repeat (30) @(posedge clock);
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h0);
        bus(1'b0, timer_capture_pkg::COUNTER_OFS, 32'h0);
        check(rdat <= 32'h5, 32'h1);
        // external clock: four rising edges give four counts
        bus(1'b1, timer_capture_pkg::CTRL_OFS, 32'h05);
        bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'h0);
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h1);
        repeat (8) begin
            repeat (3) @(posedge clock);
            ext <= ~ext;
        end
        repeat (8) @(posedge clock);
        rdchk(timer_capture_pkg::COUNTER_OFS, 32'h4);
        // buffers c and d, filter on, clear on channel a capture
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h6);
        bus(1'b1, timer_capture_pkg::CTRL_OFS, 32'h30);
        bus(1'b1, timer_capture_pkg::IO_CD_OFS, 32'hCC);
        bus(1'b1, timer_capture_pkg::IO_AB_OFS, 32'h4C);
        bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'h0200);
        pulse(4'h3, 1'b0);
        rdchk(timer_capture_pkg::GR_BASE_OFS, 32'h0200);
        rdchk(timer_capture_pkg::GR_BASE_OFS + 12'h008, 32'h5);
        rdchk(timer_capture_pkg::GR_BASE_OFS + 12'h00C, 32'h0102);
        rdchk(timer_capture_pkg::COUNTER_OFS, 32'h0);
        // free run across the wrap
        bus(1'b1, timer_capture_pkg::CTRL_OFS, 32'h0);
        bus(1'b1, timer_capture_pkg::STATUS_OFS, 32'h1F);
        bus(1'b1, timer_capture_pkg::COUNTER_OFS, 32'hFFF0);
        bus(1'b1, timer_capture_pkg::MODE_OFS, 32'h1);
        n = 0;
        while (overflow_req !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        check(n < 100, 32'h1);
        if (n >= 100)
            end_of_test;
        bus(1'b0, timer_capture_pkg::STATUS_OFS, 32'h0);
        check(rdat[4], 32'h1);
        bus(1'b0, timer_capture_pkg::COUNTER_OFS, 32'h0);
        check(rdat < 32'h0100, 32'h1);
        end_of_test;
    end
endmodule
bind timer_input_capture timer_capture_props props (
    .clock(clock), .resetn(resetn), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest),
    .chan_pin_in(chan_pin_in), .chan_pin_oe(chan_pin_oe),
    .capture_req(capture_req), .overflow_req(overflow_req));
